/* verilog/radio_cfg_pkg.sv */
// Purpose: shared constants and types for the radio link configuration bank
// Assumes: 20 MHz core clock, 8-bit register port
// Notes:   offsets are the register port addresses
package radio_cfg_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // ack wait per rate class, in ms
  localparam logic [7:0] ACK_MS_2400  = 8'd170;
  localparam logic [7:0] ACK_MS_9600  = 8'd75;
  localparam logic [7:0] ACK_MS_19200 = 8'd45;
  localparam logic [7:0] ACK_MS_FAST  = 8'd30;

  // config slot indices, shared by stored and active copies
  localparam int unsigned CFG_HOP    = 0;
  localparam int unsigned CFG_PWR    = 1;
  localparam int unsigned CFG_RATE   = 2;
  localparam int unsigned CFG_NET    = 3;
  localparam int unsigned CFG_TMO    = 4;
  localparam int unsigned CFG_RETRY  = 5;
  localparam int unsigned CFG_CRC    = 6;
  localparam int unsigned CFG_MTU    = 7;
  localparam int unsigned CFG_BANNER = 8;
  localparam int unsigned NUM_CFG    = 9;

  localparam logic [7:0] STORED_ADDR [NUM_CFG] = '{
    8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A};
  localparam logic [7:0] ACTIVE_ADDR [NUM_CFG] = '{
    8'h4B, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h52, 8'h53, 8'h54, 8'h55};
  // writable bits; the rest read as zero
  localparam logic [7:0] CFG_MASK [NUM_CFG] = '{
    8'h7F, 8'h03, 8'h07, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] CFG_RESET [NUM_CFG] = '{
    8'h00, 8'h03, 8'h00, 8'h04, 8'h10, 8'h1A, 8'h01, 8'h40, 8'h01};

  localparam logic [7:0] ADDR_CRC_COUNT = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h61;

  localparam logic [7:0] HOP_MAX   = 8'h05;
  localparam logic [7:0] MTU_MIN   = 8'h01;
  localparam logic [7:0] MTU_MAX   = 8'hC0;
  localparam logic [7:0] NET_MODE_MASK = 8'h17;   // mode bits without preamble flag
  localparam logic [7:0] NET_MAC     = 8'h04;
  localparam logic [7:0] NET_USER    = 8'h06;
  localparam logic [7:0] NET_USER_X  = 8'h07;
  localparam logic [7:0] NET_MAC_A   = 8'h14;
  localparam logic [7:0] NET_MAC_A2  = 8'h16;
  localparam logic [7:0] NET_USER_XA = 8'h17;
  localparam int unsigned NET_PREAMBLE_BIT = 3;
  localparam int unsigned NET_ACK_BIT      = 4;

  localparam logic [2:0] RATE_2400  = 3'h0;
  localparam logic [2:0] RATE_9600  = 3'h1;
  localparam logic [2:0] RATE_19200 = 3'h2;

  // interrupt status bits
  localparam int unsigned IRQ_CRC_FAIL = 0;
  localparam int unsigned IRQ_NO_ACK   = 1;
  localparam int unsigned IRQ_PKT_SENT = 2;
  localparam int unsigned IRQ_BITS     = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] hop_seq;
    logic [1:0] power_level;
    logic [2:0] serial_rate;
    logic [2:0] net_mode;
    logic       long_preamble_flag;
    logic       ack_request_flag;
    logic       crc_check_enable;
  } link_cfg_t;

endpackage : radio_cfg_pkg

/* verilog/radio_link_config_registers.sv */
// Purpose: configuration register bank and packet trigger logic of a hopping radio link
// Assumes: radio and serial engines share core_clk_i; command pin is asynchronous
// Notes:   stored copies stand in for non-volatile memory and hold defaults from reset
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps

// Operation
// - every reset or reload copies each stored setting into its active copy
// - a write to an active setting other than the rate changes the link parameter at once
// - each failed received CRC bumps the counter; writing zero clears it
// - hop sequence accepts zero to five, default zero, bit seven reserved
// - two-bit power field, lowest to highest, highest by default
// - three-bit rate code; active change applies after command acknowledge
// - stored rate applies only at reset or reload; waking from deep sleep keeps rate
// - power-on with command pin low forces 2400 baud; here the strap reads the sync chain's reset value, so the stored rate loads
// - network mode selects addressing and acknowledgement, reserved codes refused
// - long preamble flag prefixes every transmission with extended preamble
// - each serial byte reloads the ms idle timer; expiry or MTU sends
// - timeout zero disables the idle timer; only MTU triggers sending
// - acked modes retry up to the limit, then raise no-ack exception
// - ack wait is 170, 75, 45 or 30 ms by serial rate
// - CRC checking on discards failing packets; zero forwards all
// - minimum transfer unit accepts 1 to 192, default 64
// - when the hop is short, send what fits and carry the rest
module radio_link_config_registers
  import radio_cfg_pkg::*;
#(
  parameter int unsigned MS_CYCLES = radio_cfg_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    clk_en_i,
  // register port
  input  wire radio_cfg_pkg::reg_req_t reg_req_i,
  output logic [7:0]                   reg_rdata_o,
  // system control
  input  wire logic                    cmd_pin_b_i,
  input  wire logic                    soft_reset_i,
  input  wire logic                    cmd_ack_sent_i,
  // serial receive side
  input  wire logic                    uart_byte_i,
  // radio receive side
  input  wire logic                    rx_pkt_done_i,
  input  wire logic                    rx_crc_ok_i,
  output logic                         rx_forward_o,
  output logic                         rx_discard_o,
  // radio transmit side
  input  wire logic [7:0]              hop_room_i,
  input  wire logic                    tx_done_i,
  input  wire logic                    ack_ok_i,
  output logic                         send_packet_o,
  output logic [7:0]                   send_len_o,
  output logic                         no_ack_exception_o,
  // live link settings
  output radio_cfg_pkg::link_cfg_t     link_cfg_o,
  output logic [2:0]                   baud_sel_o,
  output logic                         irq_o
);

  if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_WAIT_DONE,
    TX_WAIT_ACK
  } tx_state_t;

  logic [7:0]          stored_r [NUM_CFG];
  logic [7:0]          active_r [NUM_CFG];
  logic [7:0]          crc_count_r;
  logic [2:0]          baud_r;
  logic                baud_pend_r;
  logic [2:0]          baud_nxt;
  logic                cmd_meta_r;
  logic                cmd_sync_r;
  logic                por_load_r;
  logic                por_cmd_low_r;
  logic [15:0]         ms_cnt_r;
  logic                ms_tick;
  logic [7:0]          idle_r;
  logic                idle_armed_r;
  logic [7:0]          buf_cnt_r;
  logic [7:0]          ack_ms_r;
  logic [7:0]          tries_r;
  logic [7:0]          pkt_len_r;
  tx_state_t           tx_state_r;
  logic [IRQ_BITS-1:0] irq_stat_r;
  logic [IRQ_BITS-1:0] irq_mask_r;
  logic [IRQ_BITS-1:0] irq_evt;
  logic [7:0]          rdata_r;
  logic                send_r;
  logic                no_ack_r;
  logic                fwd_r;
  logic                drop_r;
  logic                reload;
  logic                want_send;
  logic [7:0]          fit_len;
  logic [7:0]          ack_wait_ms;

  // refuse out-of-range values so the active copy never holds a bad setting
  function automatic logic write_ok(input int unsigned idx, input logic [7:0] d);
    logic [7:0] m;
    m = d & NET_MODE_MASK;
    if (idx == CFG_HOP) begin
      write_ok = (d & CFG_MASK[CFG_HOP]) <= HOP_MAX;
    end else if (idx == CFG_NET) begin
      write_ok = (m == NET_MAC) || (m == NET_USER) || (m == NET_USER_X) ||
                 (m == NET_MAC_A) || (m == NET_MAC_A2) || (m == NET_USER_XA);
    end else if (idx == CFG_MTU) begin
      write_ok = (d >= MTU_MIN) && (d <= MTU_MAX);
    end else begin
      write_ok = 1'b1;
    end
  endfunction : write_ok

  // command pin synchroniser
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_meta_r <= 1'b1;
      cmd_sync_r <= 1'b1;
    end else if (clk_en_i) begin
      cmd_meta_r <= cmd_pin_b_i;
      cmd_sync_r <= cmd_meta_r;
    end
  end

  // power-on load: sample the synchronised pin as the strap on the first cycle after release
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      por_load_r    <= 1'b1;
      por_cmd_low_r <= 1'b0;
    end else if (clk_en_i) begin
      if (por_load_r) begin
        por_load_r    <= 1'b0;
        por_cmd_low_r <= !cmd_sync_r;
      end else if (soft_reset_i) begin
        por_cmd_low_r <= 1'b0;
      end
    end
  end

  // the strap is read one cycle after release, while the sync chain still holds its reset value
  assign reload = por_load_r || soft_reset_i;

  // stored copies
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        stored_r[i] <= CFG_RESET[i];
      end
    end else if (clk_en_i && reg_req_i.wr) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        if (reg_req_i.addr == STORED_ADDR[i] && write_ok(i, reg_req_i.wdata)) begin
          stored_r[i] <= reg_req_i.wdata & CFG_MASK[i];
        end
      end
    end
  end

  // active copies; deep-sleep wake is not a reload, so nothing here reacts to it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        active_r[i] <= CFG_RESET[i];
      end
    end else if (clk_en_i) begin
      if (reload) begin
        for (int i = 0; i < NUM_CFG; i++) begin
          active_r[i] <= stored_r[i];
        end
      end else if (reg_req_i.wr) begin
        for (int i = 0; i < NUM_CFG; i++) begin
          if (reg_req_i.addr == ACTIVE_ADDR[i] && write_ok(i, reg_req_i.wdata)) begin
            active_r[i] <= reg_req_i.wdata & CFG_MASK[i];
          end
        end
      end
    end
  end

  // serial rate: stored value only at reset or reload, active change after acknowledge
  always_comb begin
    baud_nxt = stored_r[CFG_RATE][2:0];
    if (por_cmd_low_r || (por_load_r && !cmd_sync_r)) begin
      baud_nxt = RATE_2400;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      baud_r      <= RATE_2400;
      baud_pend_r <= 1'b0;
    end else if (clk_en_i) begin
      if (por_load_r) begin
        baud_r      <= baud_nxt;
        baud_pend_r <= 1'b0;
      end else if (soft_reset_i) begin
        baud_r      <= stored_r[CFG_RATE][2:0];
        baud_pend_r <= 1'b0;
      end else begin
        if (reg_req_i.wr && reg_req_i.addr == ACTIVE_ADDR[CFG_RATE]) begin
          baud_pend_r <= 1'b1;
        end else if (cmd_ack_sent_i) begin
          baud_pend_r <= 1'b0;
        end
        if (cmd_ack_sent_i && baud_pend_r) begin
          baud_r <= active_r[CFG_RATE][2:0];
        end
      end
    end
  end

  // received packets: count and filter
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc_count_r <= 8'h00;
      fwd_r       <= 1'b0;
      drop_r      <= 1'b0;
    end else if (clk_en_i) begin
      fwd_r  <= rx_pkt_done_i && (rx_crc_ok_i || active_r[CFG_CRC] == 8'h00);
      drop_r <= rx_pkt_done_i && !rx_crc_ok_i && active_r[CFG_CRC] != 8'h00;
      // an increment in the write cycle is applied on top of the written value
      if (reg_req_i.wr && reg_req_i.addr == ADDR_CRC_COUNT) begin
        crc_count_r <= reg_req_i.wdata + {7'h00, rx_pkt_done_i && !rx_crc_ok_i};
      end else if (rx_pkt_done_i && !rx_crc_ok_i) begin
        crc_count_r <= crc_count_r + 8'h01;
      end
    end
  end

  // millisecond tick
  assign ms_tick = (ms_cnt_r == 16'(MS_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ms_cnt_r <= 16'h0000;
    end else if (clk_en_i) begin
      ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
    end
  end

  // send decision; the host keeps the timeout above one byte time
  assign want_send = (buf_cnt_r != 8'h00) &&
                     ((buf_cnt_r >= active_r[CFG_MTU]) ||
                      (idle_armed_r && idle_r == 8'h00));
  assign fit_len   = (hop_room_i < buf_cnt_r) ? hop_room_i : buf_cnt_r;

  // idle timer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_r       <= 8'h00;
      idle_armed_r <= 1'b0;
    end else if (clk_en_i) begin
      if (uart_byte_i) begin
        idle_r       <= active_r[CFG_TMO];
        idle_armed_r <= active_r[CFG_TMO] != 8'h00;
      end else if (send_r) begin
        idle_armed_r <= 1'b0;
      end else if (ms_tick && idle_r != 8'h00) begin
        idle_r <= idle_r - 8'h01;
      end
    end
  end

  // buffered byte level
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_cnt_r <= 8'h00;
    end else if (clk_en_i) begin
      buf_cnt_r <= buf_cnt_r
                 + {7'h00, uart_byte_i && buf_cnt_r != 8'hFF}
                 - (send_r ? pkt_len_r : 8'h00);
    end
  end

  always_comb begin
    if (baud_r == RATE_2400) begin
      ack_wait_ms = ACK_MS_2400;
    end else if (baud_r == RATE_9600) begin
      ack_wait_ms = ACK_MS_9600;
    end else if (baud_r == RATE_19200) begin
      ack_wait_ms = ACK_MS_19200;
    end else begin
      ack_wait_ms = ACK_MS_FAST;
    end
  end

  // transmit engine with acknowledgement retries
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_state_r <= TX_IDLE;
      send_r     <= 1'b0;
      no_ack_r   <= 1'b0;
      pkt_len_r  <= 8'h00;
      tries_r    <= 8'h00;
      ack_ms_r   <= 8'h00;
    end else if (clk_en_i) begin
      send_r   <= 1'b0;
      no_ack_r <= 1'b0;
      case (tx_state_r)
        TX_IDLE: begin
          if (want_send && fit_len != 8'h00) begin
            pkt_len_r  <= fit_len;
            send_r     <= 1'b1;
            tries_r    <= 8'h01;
            tx_state_r <= TX_WAIT_DONE;
          end
        end
        TX_WAIT_DONE: begin
          if (tx_done_i) begin
            ack_ms_r   <= ack_wait_ms;
            tx_state_r <= active_r[CFG_NET][NET_ACK_BIT] ? TX_WAIT_ACK : TX_IDLE;
          end
        end
        TX_WAIT_ACK: begin
          if (ack_ok_i) begin
            tx_state_r <= TX_IDLE;
          end else if (ms_tick && ack_ms_r == 8'h01) begin
            if (tries_r >= active_r[CFG_RETRY]) begin
              no_ack_r   <= 1'b1;
              tx_state_r <= TX_IDLE;
            end else begin
              // resend the same bytes; the level is only reduced once
              tries_r    <= tries_r + 8'h01;
              tx_state_r <= TX_WAIT_DONE;
            end
          end else if (ms_tick) begin
            ack_ms_r <= ack_ms_r - 8'h01;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // interrupt status and mask
  assign irq_evt = {send_r, no_ack_r, rx_pkt_done_i && !rx_crc_ok_i};

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else if (clk_en_i) begin
      if (reg_req_i.wr && reg_req_i.addr == ADDR_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~reg_req_i.wdata[IRQ_BITS-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (reg_req_i.wr && reg_req_i.addr == ADDR_IRQ_MASK) begin
        irq_mask_r <= reg_req_i.wdata[IRQ_BITS-1:0];
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
    end else if (clk_en_i) begin
      rdata_r <= 8'h00;
      if (reg_req_i.rd) begin
        if (reg_req_i.addr == ADDR_CRC_COUNT) begin
          rdata_r <= crc_count_r;
        end else if (reg_req_i.addr == ADDR_IRQ_STAT) begin
          rdata_r <= {{(8-IRQ_BITS){1'b0}}, irq_stat_r};
        end else if (reg_req_i.addr == ADDR_IRQ_MASK) begin
          rdata_r <= {{(8-IRQ_BITS){1'b0}}, irq_mask_r};
        end else begin
          for (int i = 0; i < NUM_CFG; i++) begin
            if (reg_req_i.addr == STORED_ADDR[i]) begin
              rdata_r <= stored_r[i];
            end else if (reg_req_i.addr == ACTIVE_ADDR[i]) begin
              rdata_r <= active_r[i];
            end
          end
        end
      end
    end
  end

  // live settings
  assign link_cfg_o.hop_seq            = active_r[CFG_HOP][2:0];
  assign link_cfg_o.power_level        = active_r[CFG_PWR][1:0];
  assign link_cfg_o.serial_rate        = active_r[CFG_RATE][2:0];
  assign link_cfg_o.net_mode           = active_r[CFG_NET][2:0];
  assign link_cfg_o.long_preamble_flag = active_r[CFG_NET][NET_PREAMBLE_BIT];
  assign link_cfg_o.ack_request_flag   = active_r[CFG_NET][NET_ACK_BIT];
  assign link_cfg_o.crc_check_enable   = active_r[CFG_CRC] != 8'h00;

  assign baud_sel_o         = baud_r;
  assign reg_rdata_o        = rdata_r;
  assign rx_forward_o       = fwd_r;
  assign rx_discard_o       = drop_r;
  assign send_packet_o      = send_r;
  assign send_len_o         = pkt_len_r;
  assign no_ack_exception_o = no_ack_r;
  assign irq_o              = |(irq_stat_r & irq_mask_r);

endmodule : radio_link_config_registers

/* dv/radio_cfg_chk.sv */
// Purpose: port-level assertions for the radio link configuration bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the bank
`timescale 1ns/100ps
module radio_cfg_chk
  import radio_cfg_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 20
) (
  // clock, reset, enable
  input wire logic                     core_clk_i, rst_b_i, clk_en_i,
  // register port
  input wire radio_cfg_pkg::reg_req_t  reg_req_i,
  input wire logic [7:0]               reg_rdata_o, hop_room_i, send_len_o,
  // control and events
  input wire logic                     cmd_pin_b_i, soft_reset_i, cmd_ack_sent_i, uart_byte_i,
  input wire logic                     rx_pkt_done_i, rx_crc_ok_i, rx_forward_o, rx_discard_o,
  input wire logic                     tx_done_i, ack_ok_i, send_packet_o, no_ack_exception_o,
  input wire logic                     irq_o,
  // live settings
  input wire radio_cfg_pkg::link_cfg_t link_cfg_o,
  input wire logic [2:0]               baud_sel_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_hop_write;
    reg_req_i.wr && reg_req_i.addr == 8'h4B && reg_req_i.wdata <= 8'h05
      |=> link_cfg_o.hop_seq == $past(reg_req_i.wdata[2:0]);
  endproperty
  a_hop_write: assert property (p_hop_write) else $error("hop write not applied");
  property p_pwr_write;
    reg_req_i.wr && reg_req_i.addr == 8'h4D |=> link_cfg_o.power_level == $past(reg_req_i.wdata[1:0]);
  endproperty
  a_pwr_write: assert property (p_pwr_write) else $error("power write not applied");
  property p_hop_range;
    link_cfg_o.hop_seq <= 3'd5;
  endproperty
  a_hop_range: assert property (p_hop_range) else $error("hop out of range");
  property p_net_mode;
    link_cfg_o.net_mode inside {3'd4, 3'd6, 3'd7};
  endproperty
  a_net_mode: assert property (p_net_mode) else $error("reserved net mode");
  // rate may only move on acknowledge, reload or power-on load
  property p_rate_cause;
    $changed(baud_sel_o) |-> $past(cmd_ack_sent_i) || $past(soft_reset_i) || !$past(rst_b_i);
  endproperty
  a_rate_cause: assert property (p_rate_cause) else $error("rate changed unprompted");
  property p_crc_drop;
    rx_pkt_done_i && !rx_crc_ok_i && link_cfg_o.crc_check_enable |=> rx_discard_o && !rx_forward_o;
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("bad packet not dropped");
  property p_crc_pass;
    rx_pkt_done_i && (rx_crc_ok_i || !link_cfg_o.crc_check_enable) |=> rx_forward_o && !rx_discard_o;
  endproperty
  a_crc_pass: assert property (p_crc_pass) else $error("packet not forwarded");
  property p_send_fit;
    send_packet_o |-> send_len_o != 8'h00 && send_len_o <= $past(hop_room_i);
  endproperty
  a_send_fit: assert property (p_send_fit) else $error("send length exceeds hop room");
  property p_no_ack;
    no_ack_exception_o |-> link_cfg_o.ack_request_flag;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("no-ack outside acked mode");
  property p_rd_idle;
    !$past(reg_req_i.rd) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule : radio_cfg_chk

bind radio_link_config_registers radio_cfg_chk #(.MS_CYCLES(MS_CYCLES)) radio_cfg_chk_i (.*);

/* dv/radio_engine_model.sv */
// Purpose: radio engine model that finishes sends and answers acks
// Assumes: shares the bank clock
// Notes:   silent mode lets the bank time out and retry
`timescale 1ns/100ps
module radio_engine_model #(
  parameter int unsigned MS_CYCLES = 20,
  parameter int unsigned DLY       = 5
) (
  input  wire logic clk_i,
  input  wire logic send_i,
  input  wire logic ack_mode_i,
  input  wire logic ack_on_i,
  input  wire logic give_up_i,
  output logic      tx_done_o,
  output logic      ack_ok_o
);
  logic gave_up_r = 1'b0;
  int   w;
  always @(posedge clk_i) begin
    if (send_i === 1'b1) gave_up_r <= 1'b0;
    else if (give_up_i === 1'b1) gave_up_r <= 1'b1;
  end
  initial begin
    tx_done_o = 1'b0;
    ack_ok_o  = 1'b0;
    forever begin
      @(posedge clk_i);
      if (send_i === 1'b1) begin
        do begin
          repeat (DLY) @(posedge clk_i);
          tx_done_o <= 1'b1;
          @(posedge clk_i);
          tx_done_o <= 1'b0;
          if (ack_mode_i && ack_on_i) begin
            repeat (DLY) @(posedge clk_i);
            ack_ok_o <= 1'b1;
            @(posedge clk_i);
            ack_ok_o <= 1'b0;
          end
          // resend only once the longest fast-rate ack wait has surely run out
          if (ack_mode_i && !ack_on_i)
            for (w = 0; w < 50 * MS_CYCLES && !gave_up_r; w++) @(posedge clk_i);
        end while (ack_mode_i && !ack_on_i && !gave_up_r);
      end
    end
  end
endmodule : radio_engine_model

/* dv/radio_link_config_registers_tb.sv */
// Purpose: self-checking bench for the radio link configuration bank
// Assumes: 20 MHz clock, ms tick shortened to 20 cycles
// Notes:   the bench plays the host on the register port
`timescale 1ns/100ps
module radio_link_config_registers_tb;
  import radio_cfg_pkg::*;
  localparam int unsigned MS = 20;
  logic       core_clk_i, rst_b_i, cmd_pin_b_i, soft_reset_i, cmd_ack_sent_i, ack_on;
  logic       uart_byte_i, rx_pkt_done_i, rx_crc_ok_i, tx_done_i, ack_ok_i;
  logic       rx_forward_o, rx_discard_o, send_packet_o, no_ack_exception_o, irq_o;
  logic [7:0] reg_rdata_o, hop_room_i, send_len_o, last_len;
  logic [2:0] baud_sel_o;
  reg_req_t   rq;
  link_cfg_t  link_cfg_o;
  int         failures, checks, nsend, nexc, i;

  radio_link_config_registers #(.MS_CYCLES(MS)) radio_link_config_registers_i (
    .clk_en_i(1'b1), .reg_req_i(rq), .*);
  radio_engine_model #(.MS_CYCLES(MS)) radio_engine_model_i (.clk_i(core_clk_i),
    .send_i(send_packet_o), .ack_mode_i(link_cfg_o.ack_request_flag), .ack_on_i(ack_on),
    .give_up_i(no_ack_exception_o), .tx_done_o(tx_done_i), .ack_ok_o(ack_ok_i));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (send_packet_o === 1'b1) begin
      nsend++;
      last_len = send_len_o;
    end
    if (no_ack_exception_o === 1'b1) nexc++;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    rq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    rq.rd <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask : rd
  // bits: reload, ack sent, serial byte, packet received
  task automatic pulse(input logic [3:0] p);
    @(posedge core_clk_i);
    {soft_reset_i, cmd_ack_sent_i, uart_byte_i, rx_pkt_done_i} <= p;
    @(posedge core_clk_i);
    {soft_reset_i, cmd_ack_sent_i, uart_byte_i, rx_pkt_done_i} <= 4'h0;
    #1;
  endtask : pulse
  task automatic t_defaults;
    for (i = 0; i < NUM_CFG; i++) begin
      rd(STORED_ADDR[i], CFG_RESET[i]);
      rd(ACTIVE_ADDR[i], CFG_RESET[i]);
    end
    chk({5'h00, baud_sel_o}, 8'h00);
  endtask : t_defaults
  task automatic t_fields;
    logic [7:0] md [6] = '{8'h06, 8'h07, 8'h14, 8'h16, 8'h17, 8'h04};
    wr(8'h4B, 8'h06);
    rd(8'h4B, 8'h00);
    wr(8'h4B, 8'h05);
    rd(8'h4B, 8'h05);
    wr(8'h4D, 8'hFE);
    rd(8'h4D, 8'h02);
    wr(8'h54, 8'h00);
    wr(8'h54, 8'hC1);
    rd(8'h54, 8'h40);
    wr(8'h54, 8'hC0);
    rd(8'h54, 8'hC0);
    wr(8'h4F, 8'h05);
    rd(8'h4F, 8'h04);
    wr(8'h4F, 8'h0C);
    #1 chk({7'h00, link_cfg_o.long_preamble_flag}, 8'h01);
    for (i = 0; i < 6; i++) begin
      wr(8'h4F, md[i]);
      rd(8'h4F, md[i]);
    end
    rd(8'h30, 8'h00);
  endtask : t_fields
  task automatic t_reload;
    wr(8'h03, 8'h02);
    wr(8'h00, 8'h04);
    wr(8'h4B, 8'h01);
    pulse(4'h8);
    rd(8'h4B, 8'h04);
    chk({5'h00, baud_sel_o}, 8'h02);
  endtask : t_reload
  task automatic t_rate;
    wr(8'h4E, 8'h05);
    chk({5'h00, baud_sel_o}, 8'h02);
    rd(8'h4E, 8'h05);
    pulse(4'h4);
    @(posedge core_clk_i);
    #1 chk({5'h00, baud_sel_o}, 8'h05);
  endtask : t_rate
  task automatic t_crc;
    wr(8'h40, 8'h00);
    wr(8'h61, 8'h00);
    rx_crc_ok_i <= 1'b0;
    pulse(4'h1);
    chk({6'h00, rx_discard_o, rx_forward_o}, 8'h02);
    pulse(4'h1);
    rd(8'h40, 8'h02);
    chk({7'h00, irq_o}, 8'h00);
    wr(8'h61, 8'h01);
    #1 chk({7'h00, irq_o}, 8'h01);
    wr(8'h60, 8'h01);
    #1 chk({7'h00, irq_o}, 8'h00);
    wr(8'h53, 8'h00);
    pulse(4'h1);
    chk({6'h00, rx_discard_o, rx_forward_o}, 8'h01);
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h53, 8'h01);
    rx_crc_ok_i <= 1'b1;
    pulse(4'h1);
    chk({6'h00, rx_discard_o, rx_forward_o}, 8'h01);
  endtask : t_crc
  task automatic t_send;
    int n;
    n = nsend;
    wr(8'h50, 8'h00);
    wr(8'h54, 8'h02);
    pulse(4'h2);
    repeat (100) @(posedge core_clk_i);
    chk(8'(nsend - n), 8'h00);
    hop_room_i <= 8'h01;
    pulse(4'h2);
    repeat (4) @(posedge core_clk_i);
    chk(last_len, 8'h01);
    hop_room_i <= 8'hFF;
    repeat (20) @(posedge core_clk_i);
    pulse(4'h2);
    repeat (4) @(posedge core_clk_i);
    chk(last_len, 8'h02);
    chk(8'(nsend - n), 8'h02);
    wr(8'h54, 8'h40);
    wr(8'h50, 8'h03);
    pulse(4'h2);
    repeat (30) @(posedge core_clk_i);
    chk(8'(nsend - n), 8'h02);
    repeat (70) @(posedge core_clk_i);
    chk(8'(nsend - n), 8'h03);
  endtask : t_send
  task automatic t_ack;
    int n;
    n = nexc;
    wr(8'h52, 8'h02);
    wr(8'h4F, 8'h14);
    wr(8'h54, 8'h01);
    wr(8'h61, 8'h02);
    ack_on = 1'b0;
    pulse(4'h2);
    for (i = 0; i < 5000 && nexc == n; i++) @(posedge core_clk_i);
    chk(8'(nexc - n), 8'h01);
    // two tries 50 ms apart, then one 30 ms wait
    chk(8'(i >= 1560 && i <= 1680), 8'h01);
    #1 chk({7'h00, irq_o}, 8'h01);
    rd(8'h60, 8'h07);
    wr(8'h60, 8'h07);
    #1 chk({7'h00, irq_o}, 8'h00);
    ack_on = 1'b1;
    pulse(4'h2);
    repeat (1500) @(posedge core_clk_i);
    chk(8'(nexc - n), 8'h01);
  endtask : t_ack
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_b_i, cmd_pin_b_i, soft_reset_i, cmd_ack_sent_i} = 4'h0;
    {uart_byte_i, rx_pkt_done_i, rx_crc_ok_i, ack_on} = 4'h1;
    rq = '0;
    hop_room_i = 8'hFF;
    {failures, checks, nsend, nexc} = '0;
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    cmd_pin_b_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    t_defaults;
    t_fields;
    t_reload;
    t_rate;
    t_crc;
    t_send;
    t_ack;
    complete_run;
  end
  initial begin
    #(20000 * 50);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run;
  end
endmodule : radio_link_config_registers_tb
